// File: design/eeprom_host.sv
// Host controller that reads and programs a 512 x 8 parallel EEPROM over its pins.
// What this block does
// - Host keeps the read address valid and stable for the whole read.
// - Host holds gate high outside reads, since it drives the same bus for writes.
// - Strobe-controlled write: host holds select low with stable address and data, pulses strobe low.
// - Select-controlled write: strobe lowered first, select edges capture address, data.
// - Host waits for ready high, or for PROG_MAX_CYC cycles at most, before accessing again.
`timescale 1ns/1ns
`include "eeprom_host_consts.svh"
module eeprom_host #(
	parameter int LOCKOUT_CYC  = `LOCKOUT_CYC,
	parameter int PROG_MAX_CYC = `PROG_MAX_CYC
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  req_valid,
	input  eeprom_host_pkg::req_s      req,
	output logic                       req_ready,
	output logic                       rsp_valid,
	output logic [`DATA_W-1:0]         rsp_data,
	output logic                       rsp_timeout,
	output eeprom_host_pkg::pins_s     pins,
	output logic [`DATA_W-1:0]         byte_bus_o,
	output logic                       byte_bus_oe,
	input  wire logic [`DATA_W-1:0]    byte_bus_i,
	input  wire logic                  ready_busy
);
	eeprom_host_pkg::state_e state_q, state_d;
	eeprom_host_pkg::req_s   cur_q;
	logic [`CNT_W-1:0]       cnt_q;
	logic [`CNT_W-1:0]       lock_q;
	logic                    lock_done;
	logic                    accept;
	logic                    cnt_zero;

	// Lockout is counted from the host's own reset, as a stand-in for power good.
	assign lock_done = (lock_q == `CNT_W'(LOCKOUT_CYC));
	assign cnt_zero  = (cnt_q == '0);
	// Writes are held back until the lockout ends; reads are never held back.
	assign accept    = req_valid && req_ready && (!req.write || lock_done);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lock_q <= '0;
		end else if (!lock_done) begin
			lock_q <= lock_q + `CNT_W'(1);
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			eeprom_host_pkg::ST_IDLE: begin
				if (accept && req.write) begin
					state_d = eeprom_host_pkg::ST_WSET;
				end else if (accept) begin
					state_d = eeprom_host_pkg::ST_RSET;
				end
			end
			eeprom_host_pkg::ST_RSET: begin
				if (cnt_zero) begin
					state_d = eeprom_host_pkg::ST_RDONE;
				end
			end
			eeprom_host_pkg::ST_RDONE: begin
				state_d = eeprom_host_pkg::ST_IDLE;
			end
			eeprom_host_pkg::ST_WSET: begin
				if (cnt_zero) begin
					state_d = eeprom_host_pkg::ST_WLOW;
				end
			end
			eeprom_host_pkg::ST_WLOW: begin
				if (cnt_zero) begin
					state_d = eeprom_host_pkg::ST_WHOLD;
				end
			end
			eeprom_host_pkg::ST_WHOLD: begin
				if (cnt_zero) begin
					state_d = eeprom_host_pkg::ST_BUSY;
				end
			end
			eeprom_host_pkg::ST_BUSY: begin
				if ((cnt_q < `CNT_W'(PROG_MAX_CYC - `BUSY_ASSERT_CYC) && ready_busy)
						|| cnt_zero) begin
					state_d = eeprom_host_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = eeprom_host_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= eeprom_host_pkg::ST_IDLE;
			cur_q   <= '0;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			if (accept) begin
				cur_q <= req;
				cnt_q <= req.write ? `CNT_W'(`SETUP_CYC - 1) : `CNT_W'(`READ_ACCESS_CYC - 1);
			end else if (state_q != state_d) begin
				case (state_d)
					eeprom_host_pkg::ST_WLOW:  cnt_q <= `CNT_W'(`WRITE_PULSE_CYC - 1);
					eeprom_host_pkg::ST_WHOLD: cnt_q <= `CNT_W'(`HOLD_CYC - 1);
					eeprom_host_pkg::ST_BUSY:  cnt_q <= `CNT_W'(PROG_MAX_CYC - 1);
					default:                   cnt_q <= '0;
				endcase
			end else if (!cnt_zero) begin
				cnt_q <= cnt_q - `CNT_W'(1);
			end
		end
	end

	// Pin drive. Gate stays high through every write phase so the device accepts it.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pins        <= '{chip_select_n: 1'b1, output_gate_n: 1'b1,
				write_strobe_n: 1'b1, word_address: '0};
			byte_bus_o  <= '0;
			byte_bus_oe <= 1'b0;
			req_ready   <= 1'b0;
			rsp_valid   <= 1'b0;
			rsp_data    <= '0;
			rsp_timeout <= 1'b0;
		end else begin
			req_ready   <= (state_d == eeprom_host_pkg::ST_IDLE) && !accept;
			rsp_valid   <= 1'b0;
			rsp_timeout <= 1'b0;
			case (state_d)
				eeprom_host_pkg::ST_RSET: begin
					pins        <= '{chip_select_n: 1'b0, output_gate_n: 1'b0,
						write_strobe_n: 1'b1, word_address: accept ? req.word_address
						: cur_q.word_address};
					byte_bus_oe <= 1'b0;
				end
				eeprom_host_pkg::ST_RDONE: begin
					rsp_valid <= 1'b1;
					rsp_data  <= byte_bus_i;
				end
				eeprom_host_pkg::ST_WSET: begin
					pins.word_address   <= accept ? req.word_address : cur_q.word_address;
					byte_bus_o          <= accept ? req.data : cur_q.data;
					byte_bus_oe         <= 1'b1;
					pins.output_gate_n  <= 1'b1;
					pins.chip_select_n  <= accept ? req.sel_ctrl : cur_q.sel_ctrl;
					pins.write_strobe_n <= accept ? !req.sel_ctrl : !cur_q.sel_ctrl;
				end
				eeprom_host_pkg::ST_WLOW: begin
					pins.chip_select_n  <= 1'b0;
					pins.write_strobe_n <= 1'b0;
				end
				eeprom_host_pkg::ST_WHOLD: begin
					// Select-controlled mode ends on select; strobe-controlled on strobe.
					pins.chip_select_n  <= cur_q.sel_ctrl;
					pins.write_strobe_n <= !cur_q.sel_ctrl;
				end
				eeprom_host_pkg::ST_BUSY: begin
					pins.chip_select_n  <= 1'b1;
					pins.write_strobe_n <= 1'b1;
					byte_bus_oe         <= 1'b0;
				end
				default: begin
					if (state_q == eeprom_host_pkg::ST_BUSY) begin
						rsp_valid   <= 1'b1;
						rsp_timeout <= cnt_zero;
					end
					pins.chip_select_n  <= 1'b1;
					// Gate is not tied low, because the host drives the same bus for writes.
					pins.output_gate_n  <= 1'b1;
					pins.write_strobe_n <= 1'b1;
					byte_bus_oe         <= 1'b0;
				end
			endcase
		end
	end

	property p_gate_high_when_driving;
		@(posedge core_clk) disable iff (rst)
		byte_bus_oe |-> pins.output_gate_n;
	endproperty
	a_gate_high_when_driving: assert property (p_gate_high_when_driving)
		else $error("Data driven while output gate low.");

	property p_no_write_in_lockout;
		@(posedge core_clk) disable iff (rst)
		!lock_done |-> pins.write_strobe_n && !byte_bus_oe;
	endproperty
	a_no_write_in_lockout: assert property (p_no_write_in_lockout)
		else $error("Write strobe during lockout.");

	property p_read_pins;
		@(posedge core_clk) disable iff (rst)
		state_q == eeprom_host_pkg::ST_RSET |-> !pins.chip_select_n && !pins.output_gate_n
			&& pins.write_strobe_n && !byte_bus_oe;
	endproperty
	a_read_pins: assert property (p_read_pins)
		else $error("Read pin levels wrong.");

	property p_read_addr_stable;
		@(posedge core_clk) disable iff (rst)
		state_q == eeprom_host_pkg::ST_RSET && $past(state_q) == eeprom_host_pkg::ST_RSET
			|-> $stable(pins.word_address);
	endproperty
	a_read_addr_stable: assert property (p_read_addr_stable)
		else $error("Address moved during read.");

	property p_strobe_width;
		@(posedge core_clk) disable iff (rst)
		$fell(state_q == eeprom_host_pkg::ST_WSET) |-> (!pins.write_strobe_n
			&& !pins.chip_select_n)[*8];
	endproperty
	a_strobe_width: assert property (p_strobe_width)
		else $error("Write pulse too short.");

	property p_busy_idle_pins;
		@(posedge core_clk) disable iff (rst)
		state_q == eeprom_host_pkg::ST_BUSY |-> pins.chip_select_n && !byte_bus_oe;
	endproperty
	a_busy_idle_pins: assert property (p_busy_idle_pins)
		else $error("Device accessed while busy.");

	property p_sel_mode_order;
		@(posedge core_clk) disable iff (rst)
		state_q == eeprom_host_pkg::ST_WSET && cur_q.sel_ctrl |-> !pins.write_strobe_n
			&& pins.chip_select_n;
	endproperty
	a_sel_mode_order: assert property (p_sel_mode_order)
		else $error("Strobe not lowered before select.");

	property p_read_response;
		@(posedge core_clk) disable iff (rst)
		accept && !req.write |-> ##[38:40] rsp_valid;
	endproperty
	a_read_response: assert property (p_read_response)
		else $error("Read answer late.");
endmodule

// File: include/eeprom_host_consts.svh
// Timing counts and widths for the parallel EEPROM host controller.
`ifndef EEPROM_HOST_CONSTS_SVH
`define EEPROM_HOST_CONSTS_SVH
`define CLK_PERIOD_NS      8
`define ADDR_W             9
`define DATA_W             8
`define READ_ACCESS_NS     300
`define READ_ACCESS_CYC    ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS           50
`define SETUP_CYC          ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_NS     150
`define WRITE_PULSE_CYC    ((`WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_NS            70
`define HOLD_CYC           ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_ASSERT_NS     100
`define BUSY_ASSERT_CYC    ((`BUSY_ASSERT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCKOUT_MS         10
`define LOCKOUT_CYC        (`LOCKOUT_MS * 1000000 / `CLK_PERIOD_NS)
`define PROG_MAX_MS        40
`define PROG_MAX_CYC       (`PROG_MAX_MS * 1000000 / `CLK_PERIOD_NS)
`define CNT_W              24
`endif

// File: include/eeprom_host_pkg.sv
// Types for the parallel EEPROM host controller.
package eeprom_host_pkg;
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_RSET  = 7'h02,
		ST_RDONE = 7'h04,
		ST_WSET  = 7'h08,
		ST_WLOW  = 7'h10,
		ST_WHOLD = 7'h20,
		ST_BUSY  = 7'h40
	} state_e;

	typedef struct packed {
		logic       write;
		logic       sel_ctrl;
		logic [8:0] word_address;
		logic [7:0] data;
	} req_s;

	typedef struct packed {
		logic       chip_select_n;
		logic       output_gate_n;
		logic       write_strobe_n;
		logic [8:0] word_address;
	} pins_s;
endpackage

// File: tb/eeprom_dev_model.sv
// Behavioural model of the 512 x 8 parallel EEPROM that the host drives.
`timescale 1ns/1ns
module eeprom_dev_model #(
	parameter int LOCK_NS = 300
) (
	input  wire logic       chip_select_n,
	input  wire logic       output_gate_n,
	input  wire logic       write_strobe_n,
	input  wire logic [8:0] word_address,
	input  wire logic [7:0] byte_in,
	output logic [7:0]      byte_out,
	output logic            byte_oe,
	output logic            ready_busy,
	output int              n_viol
);
	logic [7:0] mem [512];
	logic [8:0] lat_addr;
	int         prog_ns;
	initial begin
		for (int i = 0; i < 512; i++)
			mem[i] = 8'(i) ^ 8'h5a;
		ready_busy = 1'b1;
		n_viol = 0;
		prog_ns = 800;
		lat_addr = '0;
	end
	// Data lags the address, so a host that samples early catches stale bits.
	assign #150 byte_out = mem[word_address];
	assign byte_oe = !chip_select_n && !output_gate_n && write_strobe_n && ready_busy;
	task automatic commit(input logic [7:0] d);
		logic [8:0] a;
		a = lat_addr;
		if (ready_busy && output_gate_n && $time >= LOCK_NS)
			fork
				begin
					// Strobes carry logic levels only, so the high-voltage erase modes never arise.
					#50 ready_busy = 1'b0;
					#(prog_ns) mem[a] = d;
					ready_busy = 1'b1;
				end
			join_none
	endtask
	always @(negedge write_strobe_n) begin
		if (!chip_select_n)
			lat_addr = word_address;
	end
	always @(posedge write_strobe_n) begin
		if (!chip_select_n)
			commit(byte_in);
	end
	always @(negedge chip_select_n) begin
		if (!ready_busy)
			n_viol++;
		if (!write_strobe_n)
			lat_addr = word_address;
	end
	always @(posedge chip_select_n) begin
		if (!write_strobe_n)
			commit(byte_in);
	end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the parallel EEPROM host controller.
`timescale 1ns/1ns
module tb_top;
	localparam int LOCK = 50;
	logic                   core_clk, rst, req_valid, req_ready, rsp_valid, rsp_timeout;
	eeprom_host_pkg::req_s  req;
	eeprom_host_pkg::pins_s pins;
	logic [7:0]             rsp_data, host_o, dev_o, q, d;
	logic                   host_oe, dev_oe, ready_busy, t;
	logic [8:0]             a;
	logic [7:0]             float_q = 8'h3c;
	wire  [7:0]             bus;
	int                     n_viol, n_mismatch, n_checks, rel, taken;
	int                     cyc = 0;
	int                     ref_mem [512];
	// A released bus changes on every cycle but one in 256, so no stale byte passes for data.
	assign bus = dev_oe ? dev_o : (host_oe ? host_o : float_q);
	eeprom_host #(
		.LOCKOUT_CYC (LOCK),
		.PROG_MAX_CYC(200)
	) i_dut (
		.core_clk   (core_clk),
		.rst        (rst),
		.req_valid  (req_valid),
		.req        (req),
		.req_ready  (req_ready),
		.rsp_valid  (rsp_valid),
		.rsp_data   (rsp_data),
		.rsp_timeout(rsp_timeout),
		.pins       (pins),
		.byte_bus_o (host_o),
		.byte_bus_oe(host_oe),
		.byte_bus_i (bus),
		.ready_busy (ready_busy)
	);
	eeprom_dev_model i_dev (
		.chip_select_n (pins.chip_select_n),
		.output_gate_n (pins.output_gate_n),
		.write_strobe_n(pins.write_strobe_n),
		.word_address  (pins.word_address),
		.byte_in       (bus),
		.byte_out      (dev_o),
		.byte_oe       (dev_oe),
		.ready_busy    (ready_busy),
		.n_viol        (n_viol)
	);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		float_q <= ~float_q ^ 8'(cyc);
		if (cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One request held until the design lowers ready, then wait for its answer.
	task automatic do_req(input logic w, input logic s, input logic [8:0] ad, input logic [7:0] dd);
		@(negedge core_clk);
		while (req_ready !== 1'b1)
			@(negedge core_clk);
		req_valid = 1'b1;
		req = '{write: w, sel_ctrl: s, word_address: ad, data: dd};
		do @(negedge core_clk); while (req_ready !== 1'b0);
		taken = cyc;
		req_valid = 1'b0;
		do @(negedge core_clk); while (rsp_valid !== 1'b1);
		q = rsp_data;
		t = rsp_timeout;
	endtask
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		n_mismatch = 0;
		n_checks = 0;
		for (int i = 0; i < 512; i++)
			ref_mem[i] = (i % 256) ^ 'h5a;
		void'($urandom(53979));
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		rel = cyc;
		do_req(1'b0, 1'b0, 9'h1ff, 8'h00);
		check("lockout_read", q, ref_mem[511]);
		do_req(1'b1, 1'b0, 9'h000, 8'ha5);
		check("lockout_wait", 32'(taken - rel >= LOCK), 1);
		ref_mem[0] = 'ha5;
		for (int i = 0; i < 9; i++) begin
			a = (i == 8) ? 9'h000 : 9'($urandom);
			d = 8'($urandom);
			if (i < 8)
				do_req(1'b1, i[0], a, d);
			if (i < 8)
				check("write_tmo", t, 0);
			if (i < 8)
				ref_mem[a] = d;
			do_req(1'b0, 1'b0, a, 8'h00);
			check("readback", q, ref_mem[a]);
		end
		i_dev.prog_ns = 3000;
		do_req(1'b1, 1'b0, 9'h0aa, 8'h3c);
		check("timeout", t, 1);
		ref_mem[170] = 'h3c;
		while (ready_busy !== 1'b1)
			@(negedge core_clk);
		i_dev.prog_ns = 800;
		do_req(1'b0, 1'b0, 9'h0aa, 8'h00);
		check("after_busy", q, ref_mem[170]);
		check("busy_access", n_viol, 0);
		tally_and_finish();
	end
endmodule
